// *** ssp_top.sv ***
// Synchronous 8-bit serial port with AXI4-Lite register access
//
// What this block does
// RULE1 - One 8-bit shift register serves both directions.
// RULE2 - Mode 11 osc, 10 osc/2, 01 timer, 00 slave.
// RULE3 - Timer clock is timer one underflow halved.
// RULE4 - Software starts the timer before a timer-clocked transfer.
// RULE5 - Reset selects slave mode with external clock.
// RULE6 - Master drives the clock pin; slave reads it.
// RULE7 - Master stops after eight pulses, clock pin held high.
// RULE8 - Slave takes eight pulses per transfer, ignores more.
// RULE9 - Done after eight counted shift clock cycles.
// RULE10 - Load both nibbles, write trigger; data shifts out with clock.
// RULE11 - Negative polarity: output changes on falling edge.
// RULE12 - Negative polarity: shift on fall if phase one, else rise.
// RULE13 - Positive polarity: output changes on rising edge.
// RULE14 - Positive polarity: shift on rise if phase one, else fall.
// RULE15 - Build-time polarity shared by clock and ready.
// RULE16 - Done flag sets whatever the mask; request only when unmasked.
// RULE17 - Input bits are sampled into the register with the clock.
// RULE18 - Serial output floats unless output enable is one.
// RULE19 - Shared pins are general I/O until function select is set.
// RULE20 - Slave mode drives a ready output to the master.
// RULE21 - Capture edge follows polarity and phase like shifting.
// RULE22 - Ready on at trigger; off at active clock or high nibble access.
// RULE23 - Bit order zero shifts LSB first, one MSB first.
// RULE24 - Trigger restarts the three-bit clock counter.
// RULE25 - Trigger writes during a transfer are ignored.
`timescale 1ns/100ps
module ssp_top
    import ssp_pkg::*;
#(
    parameter bit POSITIVE_POL = 1'b0 // Clock and ready polarity
)(
    input  wire logic              aclk, // System clock, 250 MHz
    input  wire logic              aresetn, // Synchronous reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr, // AW address
    input  wire logic              s_axi_awvalid, // AW valid
    output logic                   s_axi_awready, // AW ready
    input  wire logic [31:0]       s_axi_wdata, // W data
    input  wire logic [3:0]        s_axi_wstrb, // W strobes
    input  wire logic              s_axi_wvalid, // W valid
    output logic                   s_axi_wready, // W ready
    output logic [1:0]             s_axi_bresp, // B response
    output logic                   s_axi_bvalid, // B valid
    input  wire logic              s_axi_bready, // B ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr, // AR address
    input  wire logic              s_axi_arvalid, // AR valid
    output logic                   s_axi_arready, // AR ready
    output logic [31:0]            s_axi_rdata, // R data
    output logic [1:0]             s_axi_rresp, // R response
    output logic                   s_axi_rvalid, // R valid
    input  wire logic              s_axi_rready, // R ready
    input  wire logic              low_speed_oscillator, // Oscillator pin
    input  wire logic              timer1_underflow, // Timer one underflow
    input  wire logic [3:0]        shared_port_pins_in, // Pin levels
    output logic [3:0]             shared_port_pins_out, // Pin drive
    output logic [3:0]             shared_port_pins_oe, // Pin enables
    input  wire logic [3:0]        gpio_out, // GPIO drive
    input  wire logic [3:0]        gpio_oe, // GPIO enables
    output logic [3:0]             gpio_in, // Synced pin levels
    output logic                   transfer_irq // Done request
);
    ssp_clk_if cif ();

    // Input synchronisers
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic       osc_s1_reg;
    logic       osc_s2_reg;
    logic       osc_prev_reg;

    // Registers
    logic       func_sel_reg;
    logic       out_en_reg;
    logic [3:0] mode_reg;
    logic [7:0] shift_reg;
    logic       mask_reg;
    logic       flag_reg;
    logic       busy_reg;
    logic [2:0] bit_cnt_reg;
    logic       out_bit_reg;
    logic       ready_reg;
    logic       lvl_prev_reg;

    // AXI state
    logic        aw_held_reg;
    logic [15:0] aw_idx_reg;
    logic        w_held_reg;
    logic [7:0]  w_byte_reg;
    logic        w_en_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_s1_reg[gi] <= 1'b0;
                    pin_s2_reg[gi] <= 1'b0;
                end else begin
                    pin_s1_reg[gi] <= shared_port_pins_in[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_s1_reg   <= 1'b0;
            osc_s2_reg   <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_s1_reg   <= low_speed_oscillator;
            osc_s2_reg   <= osc_s1_reg;
            osc_prev_reg <= osc_s2_reg;
        end
    end

    // Decoded mode and clock edges
    logic master;
    logic phase;
    logic msb_first;
    logic lvl;
    logic rise;
    logic fall;
    logic lead_edge;
    logic shift_edge;
    logic active_lvl;
    logic shift_out_bit;

    assign master        = mode_reg[MODE_HI:MODE_LO] != CLK_SLAVE; // RULE2
    assign phase         = mode_reg[MODE_PHASE];
    assign msb_first     = mode_reg[MODE_ORDER];
    assign lvl           = master ? cif.lvl : pin_s2_reg[PIN_SCLK]; // RULE6
    assign rise          = lvl & ~lvl_prev_reg;
    assign fall          = ~lvl & lvl_prev_reg;
    assign lead_edge     = POSITIVE_POL ? rise : fall; // RULE11 RULE13 RULE15
    // Shift and capture share one edge
    assign shift_edge    = phase ? lead_edge : (POSITIVE_POL ? fall : rise); // RULE12 RULE14 RULE21
    assign active_lvl    = POSITIVE_POL ? lvl : ~lvl; // RULE15
    assign shift_out_bit = msb_first ? shift_reg[7] : shift_reg[0]; // RULE23

    assign cif.mode     = mode_reg[MODE_HI:MODE_LO];
    assign cif.osc_rise = osc_s2_reg & ~osc_prev_reg;
    assign cif.osc_fall = ~osc_s2_reg & osc_prev_reg;
    assign cif.tmr_tick = timer1_underflow;

    ssp_clkgen u_clkgen (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cif     (cif)
    );

    // Register access decode
    logic        do_write;
    logic        wr_ctrl;
    logic        wr_mode;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_mask;
    logic        wr_flag;
    logic        wr_hit;
    logic [15:0] rd_idx;
    logic        rd_take;
    logic        rd_hi;
    logic        trig;

    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_ctrl  = do_write & w_en_reg & (aw_idx_reg == IDX_CTRL);
    assign wr_mode  = do_write & w_en_reg & (aw_idx_reg == IDX_MODE);
    assign wr_lo    = do_write & w_en_reg & (aw_idx_reg == IDX_DATA_LO);
    assign wr_hi    = do_write & w_en_reg & (aw_idx_reg == IDX_DATA_HI);
    assign wr_mask  = do_write & w_en_reg & (aw_idx_reg == IDX_IRQ_MASK);
    assign wr_flag  = do_write & w_en_reg & (aw_idx_reg == IDX_IRQ_FLAG);
    assign wr_hit   = aw_idx_reg inside {IDX_CTRL, IDX_MODE, IDX_DATA_LO,
        IDX_DATA_HI, IDX_IRQ_MASK, IDX_IRQ_FLAG};
    assign rd_idx   = s_axi_araddr[ADDR_W-1:2];
    assign rd_take  = s_axi_arvalid & ~rvalid_reg;
    assign rd_hi    = rd_take & (rd_idx == IDX_DATA_HI);
    assign trig     = wr_ctrl & w_byte_reg[CTRL_TRIGGER] & ~busy_reg; // RULE10 RULE25

    // AXI write: address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg  <= 16'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[ADDR_W-1:2];
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_byte_reg <= 8'h00;
            w_en_reg   <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_byte_reg <= s_axi_wdata[7:0];
            w_en_reg   <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // AXI read: data one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            case (rd_idx)
                IDX_CTRL:     rdata_reg <= {29'h0, out_en_reg, busy_reg, func_sel_reg};
                IDX_MODE:     rdata_reg <= {28'h0, mode_reg};
                IDX_DATA_LO:  rdata_reg <= {28'h0, shift_reg[3:0]};
                IDX_DATA_HI:  rdata_reg <= {28'h0, shift_reg[7:4]};
                IDX_IRQ_MASK: rdata_reg <= {31'h0, mask_reg};
                IDX_IRQ_FLAG: rdata_reg <= {31'h0, flag_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func_sel_reg <= 1'b0; // RULE19
            out_en_reg   <= 1'b0;
        end else if (wr_ctrl) begin
            func_sel_reg <= w_byte_reg[CTRL_FUNC_SEL]; // RULE19
            out_en_reg   <= w_byte_reg[CTRL_OUT_EN];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= MODE_RESET; // RULE5
        end else if (wr_mode) begin
            mode_reg <= w_byte_reg[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= 1'b0;
        end else if (wr_mask) begin
            mask_reg <= w_byte_reg[IRQ_BIT];
        end
    end

    assign cif.start = trig & master;

    // Transfer sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_prev_reg <= 1'b1;
        end else begin
            lvl_prev_reg <= lvl;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_reg    <= 1'b0;
            bit_cnt_reg <= CNT_RESET;
        end else if (trig) begin
            busy_reg    <= 1'b1;
            bit_cnt_reg <= CNT_RESET; // RULE24
        end else if (busy_reg && shift_edge) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == CNT_LAST) begin
                busy_reg <= 1'b0; // RULE8 RULE9
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_reg <= DATA_RESET;
        end else if (busy_reg && shift_edge) begin
            if (msb_first) begin
                shift_reg <= {shift_reg[6:0], pin_s2_reg[PIN_SIN]}; // RULE1 RULE17 RULE23
            end else begin
                shift_reg <= {pin_s2_reg[PIN_SIN], shift_reg[7:1]}; // RULE1 RULE17 RULE23
            end
        end else if (!busy_reg && wr_lo) begin
            shift_reg[3:0] <= w_byte_reg[3:0]; // RULE10
        end else if (!busy_reg && wr_hi) begin
            shift_reg[7:4] <= w_byte_reg[3:0]; // RULE10
        end
    end

    // Output bit moves on the leading edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_bit_reg <= 1'b0;
        end else if (trig) begin
            out_bit_reg <= 1'b0;
        end else if (busy_reg && lead_edge) begin
            out_bit_reg <= shift_out_bit; // RULE11 RULE13
        end
    end

    // Set beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= 1'b0;
        end else if (busy_reg && shift_edge && bit_cnt_reg == CNT_LAST) begin
            flag_reg <= 1'b1; // RULE16
        end else if (wr_flag && w_byte_reg[IRQ_BIT]) begin
            flag_reg <= 1'b0;
        end
    end

    assign transfer_irq = flag_reg & mask_reg; // RULE16

    // Slave ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_reg <= 1'b0;
        end else if (trig && !master) begin
            ready_reg <= 1'b1; // RULE22
        end else if ((!master && active_lvl) || wr_hi || rd_hi) begin
            ready_reg <= 1'b0; // RULE22
        end
    end

    // Pin mux
    always_comb begin
        shared_port_pins_out = gpio_out;
        shared_port_pins_oe  = gpio_oe;
        if (func_sel_reg) begin
            shared_port_pins_out[PIN_SIN]  = 1'b0;
            shared_port_pins_oe[PIN_SIN]   = 1'b0;
            shared_port_pins_out[PIN_SERIAL_OUT_PIN] = out_bit_reg;
            shared_port_pins_oe[PIN_SERIAL_OUT_PIN]  = out_en_reg; // RULE18
            shared_port_pins_out[PIN_SCLK] = cif.lvl; // RULE6 RULE7
            shared_port_pins_oe[PIN_SCLK]  = master; // RULE6
            if (!master) begin
                shared_port_pins_out[PIN_READY] = POSITIVE_POL ? ready_reg : ~ready_reg; // RULE15 RULE20
                shared_port_pins_oe[PIN_READY]  = 1'b1; // RULE20
            end
        end
    end

    assign gpio_in = pin_s2_reg;
endmodule

// *** ssp_pkg.sv ***
// Shared constants of the serial port
package ssp_pkg;
    // Register indices; the AXI byte address is four times the index
    localparam logic [15:0] IDX_CTRL      = 16'hff70;
    localparam logic [15:0] IDX_MODE      = 16'hff71;
    localparam logic [15:0] IDX_DATA_LO   = 16'hff72;
    localparam logic [15:0] IDX_DATA_HI   = 16'hff73;
    localparam logic [15:0] IDX_IRQ_MASK  = 16'hffe3;
    localparam logic [15:0] IDX_IRQ_FLAG  = 16'hfff3;
    localparam int          ADDR_W        = 18;

    // Control register fields
    localparam int CTRL_FUNC_SEL = 0;
    localparam int CTRL_TRIGGER  = 1;
    localparam int CTRL_OUT_EN   = 2;
    // Mode register fields
    localparam int MODE_LO       = 0;
    localparam int MODE_HI       = 1;
    localparam int MODE_PHASE    = 2;
    localparam int MODE_ORDER    = 3;
    // Mask and flag bit
    localparam int IRQ_BIT       = 0;

    // Clock mode field encodings
    localparam logic [1:0] CLK_OSC      = 2'h3;
    localparam logic [1:0] CLK_OSC_DIV2 = 2'h2;
    localparam logic [1:0] CLK_TIMER    = 2'h1;
    localparam logic [1:0] CLK_SLAVE    = 2'h0;

    // Values after reset, and the last bit count
    localparam logic [3:0] MODE_RESET   = 4'h0;
    localparam logic [7:0] DATA_RESET   = 8'h00;
    localparam logic [2:0] CNT_RESET    = 3'h0;
    localparam logic [2:0] CNT_LAST     = 3'h7;

    // Shared port pin positions
    localparam int PIN_SIN   = 0;
    localparam int PIN_SERIAL_OUT_PIN  = 1;
    localparam int PIN_SCLK  = 2;
    localparam int PIN_READY = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** ssp_clk_if.sv ***
// Port core to clock generator signals
`timescale 1ns/100ps
interface ssp_clk_if;
    logic       start;     // Begin an 8-pulse burst
    logic [1:0] mode;      // Clock mode field
    logic       osc_rise;  // Oscillator rising edge seen
    logic       osc_fall;  // Oscillator falling edge seen
    logic       tmr_tick;  // Timer channel one underflow
    logic       lvl;       // Generated clock pin level
    logic       running;   // Burst in progress

    modport core (output start, output mode, output osc_rise, output osc_fall,
                  output tmr_tick, input lvl, input running);
    modport gen  (input start, input mode, input osc_rise, input osc_fall,
                  input tmr_tick, output lvl, output running);
endinterface

// *** ssp_clkgen.sv ***
// Master shift clock generator with 8-pulse burst
`timescale 1ns/100ps
module ssp_clkgen
    import ssp_pkg::*;
(
    input  wire logic aclk,     // System clock
    input  wire logic aresetn,  // Synchronous reset, active low
    ssp_clk_if.gen    cif       // Link to the port core
);
    logic       lvl_reg;
    logic       run_reg;
    logic [2:0] pulse_cnt_reg;
    logic       tick;

    // One tick per half period
    always_comb begin
        case (cif.mode)
            CLK_OSC:      tick = cif.osc_rise | cif.osc_fall; // RULE2
            CLK_OSC_DIV2: tick = cif.osc_rise; // RULE2
            CLK_TIMER:    tick = cif.tmr_tick; // RULE3
            default:      tick = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_reg       <= 1'b1;
            run_reg       <= 1'b0;
            pulse_cnt_reg <= CNT_RESET;
        end else if (cif.start) begin
            lvl_reg       <= 1'b1;
            run_reg       <= 1'b1;
            pulse_cnt_reg <= CNT_RESET;
        end else if (run_reg && tick) begin
            lvl_reg <= ~lvl_reg;
            if (!lvl_reg) begin
                pulse_cnt_reg <= pulse_cnt_reg + 3'h1;
                if (pulse_cnt_reg == CNT_LAST) begin
                    run_reg <= 1'b0; // RULE7
                end
            end
        end
    end

    assign cif.lvl     = lvl_reg;
    assign cif.running = run_reg;
endmodule

// *** ssp_top_props.sv ***
// Port-level assertions of the serial port
`timescale 1ns/100ps
module ssp_top_props
    import ssp_pkg::*;
(
    input wire logic       aclk, // Clock
    input wire logic       aresetn, // Reset, active low
    input wire logic       s_axi_awvalid, // Aw valid
    input wire logic       s_axi_awready, // Aw ready
    input wire logic       s_axi_wvalid, // W valid
    input wire logic       s_axi_wready, // W ready
    input wire logic       s_axi_bvalid, // B valid
    input wire logic       s_axi_bready, // B ready
    input wire logic       s_axi_arvalid, // Ar valid
    input wire logic       s_axi_arready, // Ar ready
    input wire logic       s_axi_rvalid, // R valid
    input wire logic       s_axi_rready, // R ready
    input wire logic [3:0] shared_port_pins_in, // Pin levels
    input wire logic [3:0] shared_port_pins_out, // Pin drive
    input wire logic [3:0] shared_port_pins_oe, // Pin enables
    input wire logic [3:0] gpio_out, // Gpio drive
    input wire logic [3:0] gpio_oe, // Gpio enables
    input wire logic [3:0] gpio_in // Gpio levels
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER: assert property (s_wr |-> ##2 s_axi_bvalid) else $error("no write answer");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
    AST_RD_ANSWER: assert property (s_rd |=> s_axi_rvalid) else $error("no read answer");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r dropped");
    AST_GPIO_MUX: assert property (!$past(aresetn) |-> shared_port_pins_oe == gpio_oe &&
        shared_port_pins_out == gpio_out) else $error("pins not gpio");
    AST_SYNC_IN: assert property ($past(aresetn) && $past(aresetn, 2) |->
        gpio_in == $past(shared_port_pins_in, 2)) else $error("gpio in latency");
    AST_CLK_IDLE: assert property ($rose(shared_port_pins_oe[2]) && !gpio_oe[2] |->
        shared_port_pins_out[2]) else $error("clock low");
    AST_RDY_SLAVE: assert property (shared_port_pins_oe[3] && !gpio_oe[3] |->
        !shared_port_pins_oe[2]) else $error("slave drives clock");
endmodule
bind ssp_top ssp_top_props u_props (.*);

// *** ssp_peer.sv ***
// Far-side serial device model
`timescale 1ns/100ps
module ssp_peer (
    input  wire logic       aclk,     // Clock
    input  wire logic       clk_lvl,  // Clock wire level
    input  wire logic       serial_out_pin_lvl, // Data wire from port
    input  wire logic       go,       // Restart, send pulses
    input  wire logic [3:0] npulse,   // Pulses to send
    input  wire logic [7:0] tx,       // Byte to send
    output logic            clk_drv,  // Own clock drive
    output logic            serial_in_pin,      // Data into port
    output logic [7:0]      rx,       // Byte received
    output logic [3:0]      nrise     // Rising edges seen
);
    logic       prev = 1'b1;
    logic [2:0] tmr  = 3'h0;
    logic [2:0] bitn = 3'h0;
    logic [4:0] half = 5'h0;
    initial clk_drv = 1'b1;
    initial serial_in_pin = 1'b0;
    initial rx = 8'h00;
    initial nrise = 4'h0;
    always @(posedge aclk) begin
        prev <= clk_lvl;
        if (half != 5'h0) begin
            tmr <= tmr + 3'h1;
            if (tmr == 3'h7) begin
                clk_drv <= ~clk_drv;
                half <= half - 5'h1;
            end
        end
        // Drive on fall, sample on rise
        if (prev && !clk_lvl) begin
            serial_in_pin <= tx[bitn];
            bitn <= bitn + 3'h1;
        end
        if (!prev && clk_lvl) begin
            rx <= {serial_out_pin_lvl, rx[7:1]};
            nrise <= nrise + 4'h1;
        end
        if (go) begin
            half <= {npulse, 1'b0};
            tmr <= 3'h0;
            bitn <= 3'h0;
            nrise <= 4'h0;
        end
    end
endmodule

// *** tb_ssp_top.sv ***
// Self-checking serial port bench
`timescale 1ns/100ps
module tb_ssp_top;
    import ssp_pkg::*;
    logic              aclk = 1'b0, aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata, lfsr = 32'ha8a1;
    logic [3:0]        s_axi_wstrb = 4'hf, gpio_out, gpio_oe, gpio_in, np = 4'h0, nr;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0, serial_out_pin_q = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              low_speed_oscillator = 1'b0, timer1_underflow = 1'b0, transfer_irq, pclk, psin;
    logic [3:0]        shared_port_pins_in, shared_port_pins_out, shared_port_pins_oe, tc = 4'h0;
    logic [7:0]        tx = 8'h00, rx;
    int                fail_count = 0, total_checks = 0;
    wire               clk_w = shared_port_pins_oe[2] ? shared_port_pins_out[2] : pclk;
    wire               serial_out_pin_w = shared_port_pins_oe[1] ? shared_port_pins_out[1] : ~serial_out_pin_q;
    assign shared_port_pins_in = {shared_port_pins_oe[3] ? shared_port_pins_out[3] : 1'b1, clk_w, serial_out_pin_w, psin};
    ssp_top u_dut (.*);
    ssp_peer u_peer (.aclk(aclk), .clk_lvl(clk_w), .serial_out_pin_lvl(serial_out_pin_w), .go(go), .npulse(np), .tx(tx),
                     .clk_drv(pclk), .serial_in_pin(psin), .rx(rx), .nrise(nr));
    always #2 aclk = ~aclk;
    always #61 low_speed_oscillator = ~low_speed_oscillator;
    always @(posedge aclk) begin
        tc <= tc + 4'h1;
        timer1_underflow <= (tc == 4'h0);
        if (shared_port_pins_oe[1]) serial_out_pin_q <= shared_port_pins_out[1];
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] rev(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rev[i] = x[7-i];
    endfunction
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic guard(inout int n);
        n++;
        if (n > 60) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic axw(input logic [15:0] idx, input logic [3:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {28'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            guard(n);
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            guard(n);
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axr(idx, d, r);
        chk(d, e);
        chk(r, er);
    endtask
    task automatic wait_done();
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < 400; k++) begin
            axr(IDX_CTRL, d, r);
            if (d[CTRL_TRIGGER] === 1'b0) return;
        end
        fail_count++;
        end_of_test();
    endtask
    task automatic restart(input logic [7:0] b, input logic [3:0] n);
        tx <= b;
        np <= n;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
    endtask
    initial begin
        logic [1:0] r, m;
        logic [7:0] v, p;
        lfsr = nx(lfsr);
        gpio_out = lfsr[3:0];
        gpio_oe = lfsr[7:4];
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(IDX_MODE, MODE_RESET, RESP_OKAY);
        rdc(IDX_CTRL, 32'h0, RESP_OKAY);
        rdc(16'h0010, 32'h0, RESP_SLVERR);
        axw(16'h0010, 4'hf, r);
        chk(r, RESP_SLVERR);
        for (int i = 3; i > 0; i--) begin
            m = i[1:0];
            lfsr = nx(lfsr);
            v = lfsr[7:0];
            p = lfsr[15:8];
            axw(IDX_MODE, {m == CLK_OSC_DIV2, 1'b0, m}, r);
            axw(IDX_DATA_LO, v[3:0], r);
            axw(IDX_DATA_HI, v[7:4], r);
            axw(IDX_IRQ_MASK, {3'h0, m[0]}, r);
            axw(IDX_CTRL, 4'h5, r);
            restart(p, 4'h0);
            axw(IDX_CTRL, 4'h7, r);
            axw(IDX_CTRL, 4'h7, r);
            wait_done();
            chk(nr, 4'h8);
            chk(clk_w, 1'b1);
            chk(rx, (m == CLK_OSC_DIV2) ? rev(v) : v);
            p = (m == CLK_OSC_DIV2) ? rev(p) : p;
            rdc(IDX_DATA_LO, p[3:0], RESP_OKAY);
            rdc(IDX_DATA_HI, p[7:4], RESP_OKAY);
            rdc(IDX_IRQ_FLAG, 32'h1, RESP_OKAY);
            chk(transfer_irq, m[0]);
            axw(IDX_IRQ_FLAG, 4'h1, r);
            rdc(IDX_IRQ_FLAG, 32'h0, RESP_OKAY);
        end
        lfsr = nx(lfsr);
        p = lfsr[7:0];
        axw(IDX_MODE, 4'h0, r);
        axw(IDX_CTRL, 4'h1, r);
        chk(shared_port_pins_oe[1], 1'b0);
        axw(IDX_CTRL, 4'h3, r);
        repeat (3) @(posedge aclk);
        chk({shared_port_pins_oe[3], shared_port_pins_out[3]}, 2'h2);
        restart(p, 4'h9);
        wait_done();
        for (int k = 0; k < 200 && nr != 4'h9; k++) @(posedge aclk);
        chk(nr, 4'h9);
        rdc(IDX_DATA_LO, p[3:0], RESP_OKAY);
        rdc(IDX_DATA_HI, p[7:4], RESP_OKAY);
        chk(shared_port_pins_out[3], 1'b1);
        rdc(IDX_IRQ_FLAG, 32'h1, RESP_OKAY);
        end_of_test();
    end
endmodule
